// [design/mts_sequencer.sv]
`timescale 1ns/1ps
`include "mts_map.svh"
module mts_sequencer #(
  parameter int DELAY_STEP_CYC = `MTS_DELAY_STEP_CYC,
  parameter int REF_W          = 10,
  parameter int NV_WORDS       = 3
) (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  input  wire logic                 token_in,
  input  wire logic                 enable_pin,
  input  wire logic                 low_power_standby,
  input  wire logic                 addr_from_strap,
  input  wire logic [15:0]          nv_data,
  input  wire logic                 fb_below_ref,
  input  wire logic [15:0]          on_time_cyc,
  input  wire logic [REF_W-1:0]     boot_code,
  input  wire logic                 local_fault,
  input  wire logic                 pg_line_in,
  input  wire mts_pkg::mts_bus_req_s bus_req,
  output mts_pkg::mts_bus_rsp_s     bus_rsp,
  output logic [1:0]                nv_addr,
  output logic                      turn_on_req,
  output logic                      high_side_switch,
  output logic                      token_out,
  output logic                      is_master,
  output logic                      bus_enabled,
  output logic                      quiet_mode,
  output logic                      use_strap_addr,
  output logic                      slave_fault,
  output logic                      pg_line_oe_n,
  output logic [REF_W-1:0]          ref_code,
  output logic                      startup_done,
  output logic [15:0]               fsw_setting
);
  logic [2:0]  tok_sync_q;
  logic [2:0]  en_sync_q;
  logic [2:0]  pg_sync_q;
  logic        tok_lvl_q, en_lvl_q, pg_lvl_q;
  logic        tok_fall;
  mts_pkg::mts_state_e state_q;
  logic [7:0]  on_off_q;
  logic [15:0] turn_on_delay_setting_q;
  logic [15:0] nv_mem_q [NV_WORDS];
  logic [1:0]  load_idx_q;
  logic [9:0]  delay_cnt_q;
  logic [31:0] step_cnt_q;
  logic        armed_q;
  logic [15:0] on_cnt_q;
  logic [7:0]  tok_cnt_q;
  logic [7:0]  gap_cnt_q;
  logic        first_done_q;
  logic        bus_ok;

  function automatic logic agree(input logic [2:0] s, input logic cur);
    agree = (s[1] == s[2]) ? s[2] : cur;
  endfunction : agree

  // three-stage input capture, change counted when last two agree
  // the stages keep shifting in reset so the master strap is settled
  // by the time the load phase samples it
  always_ff @(posedge clock) begin
    tok_sync_q <= {tok_sync_q[1:0], token_in};
    en_sync_q  <= {en_sync_q[1:0], enable_pin};
    pg_sync_q  <= {pg_sync_q[1:0], pg_line_in};
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tok_lvl_q  <= 1'b0;
      en_lvl_q   <= 1'b0;
      pg_lvl_q   <= 1'b1;
    end else begin
      tok_lvl_q  <= agree(tok_sync_q, tok_lvl_q);
      en_lvl_q   <= agree(en_sync_q, en_lvl_q);
      pg_lvl_q   <= agree(pg_sync_q, pg_lvl_q);
    end
  end
  assign tok_fall = tok_lvl_q & ~agree(tok_sync_q, tok_lvl_q);

  // master strap caught during load, frozen once load ends
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      is_master <= 1'b0;
    end else if (state_q == mts_pkg::ST_LOAD) begin
      is_master <= agree(tok_sync_q, tok_lvl_q); // see [R1] see [R2]
    end
  end

  // start-up sequence
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q        <= mts_pkg::ST_LOAD;
      load_idx_q     <= 2'h0;
      delay_cnt_q    <= 10'h000;
      step_cnt_q     <= 32'h0;
      ref_code       <= '0;
      startup_done   <= 1'b0;
      use_strap_addr <= 1'b0;
    end else begin
      case (state_q)
        mts_pkg::ST_LOAD: begin
          load_idx_q <= load_idx_q + 2'h1; // see [R14]
          if (load_idx_q == 2'(NV_WORDS - 1)) begin
            use_strap_addr <= addr_from_strap; // see [R15]
            state_q <= mts_pkg::ST_WAIT_EN; // see [R16]
          end
        end
        mts_pkg::ST_WAIT_EN: begin
          if (en_lvl_q) state_q <= mts_pkg::ST_WAIT_ON;
        end
        mts_pkg::ST_WAIT_ON: begin
          if (!en_lvl_q) begin
            state_q <= mts_pkg::ST_WAIT_EN;
          end else if (on_off_q[`MTS_ON_BIT]) begin // see [R17]
            state_q     <= mts_pkg::ST_DELAY;
            delay_cnt_q <= 10'h000;
            step_cnt_q  <= 32'h0;
          end
        end
        mts_pkg::ST_DELAY: begin
          if (delay_cnt_q >= turn_on_delay_setting_q[9:0]) begin // see [R18]
            state_q <= mts_pkg::ST_RAMP;
          end else if (step_cnt_q == 32'(DELAY_STEP_CYC - 1)) begin
            step_cnt_q  <= 32'h0;
            delay_cnt_q <= delay_cnt_q + 10'h001; // see [R20]
          end else begin
            step_cnt_q <= step_cnt_q + 32'h1;
          end
        end
        mts_pkg::ST_RAMP: begin
          if (ref_code >= boot_code) begin
            state_q      <= mts_pkg::ST_RUN;
            startup_done <= 1'b1; // see [R19]
          end else begin
            ref_code <= ref_code + 1'b1;
          end
        end
        mts_pkg::ST_RUN: begin
          ref_code <= boot_code;
        end
        default: state_q <= mts_pkg::ST_LOAD;
      endcase
    end
  end

  // nonvolatile image copy
  always_ff @(posedge clock) begin
    if (state_q == mts_pkg::ST_LOAD) begin
      nv_mem_q[load_idx_q] <= nv_data; // see [R14]
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) nv_addr <= 2'h0;
    else nv_addr <= load_idx_q + 2'h1;
  end

  // bus gating and power mode
  assign bus_ok = (state_q != mts_pkg::ST_LOAD)
                  && (en_lvl_q || !low_power_standby); // see [R12] see [R13]
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus_enabled <= 1'b0;
      quiet_mode  <= 1'b0;
    end else begin
      bus_enabled <= bus_ok; // see [R16]
      quiet_mode  <= low_power_standby && !en_lvl_q; // see [R12]
    end
  end

  // operating registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      on_off_q    <= `MTS_RST_ON_OFF;
      turn_on_delay_setting_q <= `MTS_RST_TURN_ON_DELAY_SETTING;
      fsw_setting <= `MTS_RST_FSW;
      bus_rsp     <= '0;
    end else if (state_q == mts_pkg::ST_LOAD) begin
      case (load_idx_q)
        2'h0: on_off_q <= nv_data[7:0];
        2'h1: turn_on_delay_setting_q <= nv_data;
        2'h2: fsw_setting <= nv_data; // see [R8]
        default: ;
      endcase
    end else begin
      bus_rsp <= '0;
      if (bus_ok && bus_req.wr) begin
        bus_rsp.ack <= 1'b1;
        case (bus_req.addr)
          `MTS_OFS_ON_OFF:    on_off_q    <= bus_req.wdata[7:0];
          `MTS_OFS_TURN_ON_DELAY_SETTING: turn_on_delay_setting_q <= bus_req.wdata;
          `MTS_OFS_FSW:       fsw_setting <= bus_req.wdata;
          default:            bus_rsp <= '{ack: 1'b0, nak: 1'b1, rdata: 16'h0};
        endcase
      end else if (bus_ok && bus_req.rd) begin
        if (!is_master) begin
          bus_rsp.nak <= 1'b1; // see [R3]
        end else begin
          bus_rsp.ack <= 1'b1;
          case (bus_req.addr)
            `MTS_OFS_ON_OFF:    bus_rsp.rdata <= {8'h00, on_off_q};
            `MTS_OFS_TURN_ON_DELAY_SETTING: bus_rsp.rdata <= turn_on_delay_setting_q;
            `MTS_OFS_FSW:       bus_rsp.rdata <= fsw_setting;
            default: bus_rsp <= '{ack: 1'b0, nak: 1'b1, rdata: 16'h0};
          endcase
        end
      end
    end
  end

  // turn-on request generation by master, spaced by minimum gap
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      turn_on_req <= 1'b0;
      gap_cnt_q   <= 8'h00;
    end else begin
      turn_on_req <= 1'b0;
      if (gap_cnt_q != 8'h00) gap_cnt_q <= gap_cnt_q - 8'h01;
      if (is_master && startup_done && fb_below_ref
          && gap_cnt_q == 8'h00) begin // see [R4] see [R11]
        turn_on_req <= 1'b1;
        gap_cnt_q   <= 8'(`MTS_MIN_GAP_CYC - 1);
      end
    end
  end

  // armed flag, on pulse and token pulse
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      armed_q          <= 1'b0;
      first_done_q     <= 1'b0;
      high_side_switch <= 1'b0;
      on_cnt_q         <= 16'h0000;
      token_out        <= 1'b0;
      tok_cnt_q        <= 8'h00;
    end else begin
      if (is_master && startup_done && !first_done_q) begin
        armed_q      <= 1'b1; // see [R9]
        first_done_q <= 1'b1;
      end else if (startup_done && turn_on_req && armed_q
                   && !high_side_switch) begin
        armed_q          <= tok_fall; // see [R21] see [R6]
        high_side_switch <= 1'b1; // see [R4]
        on_cnt_q         <= on_time_cyc; // see [R8]
        token_out        <= 1'b1; // see [R5]
        tok_cnt_q        <= 8'(`MTS_TOKEN_CYC);
      end else if (tok_fall && startup_done) begin
        armed_q <= 1'b1; // see [R6]
      end
      if (high_side_switch) begin
        if (on_cnt_q <= 16'h0001) high_side_switch <= 1'b0; // see [R7]
        else on_cnt_q <= on_cnt_q - 16'h0001;
      end
      if (token_out) begin
        if (tok_cnt_q <= 8'h01) token_out <= 1'b0; // see [R5]
        else tok_cnt_q <= tok_cnt_q - 8'h01;
      end
    end
  end

  // fault reporting on power-good line
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pg_line_oe_n <= 1'b1;
      slave_fault  <= 1'b0;
    end else begin
      pg_line_oe_n <= !(!is_master && local_fault); // see [R10]
      if (is_master && startup_done && !pg_lvl_q) slave_fault <= 1'b1;
      else if (!is_master) slave_fault <= 1'b0; // see [R10]
    end
  end
endmodule : mts_sequencer

// [design/mts_map.svh]
// Summary of operation
// [R1] token-in high at start-up makes this phase master, otherwise slave.
// [R2] system chains token-out to next token-in; lone phase loops itself.
// [R3] master takes bus reads and writes; slave takes writes only.
// [R4] master raises turn-on request; only the armed phase switches on.
// [R5] switching on also drives a fixed-width token-out pulse.
// [R6] falling edge on token-in arms the phase until next request.
// [R7] on pulse ends and high-side switch turns off when width expires.
// [R8] nominal on time is vout over vin times period from 0xD1.
// [R9] master issues the first pulse and owns start-up.
// [R10] slaves report faults on power-good line; master watches it.
// [R11] requests may repeat at the minimum interval during load steps.
// [R12] low-power mode with enable low blocks bus and cuts quiescent use.
// [R13] regular power mode keeps the bus available while enable is low.
// [R14] after power-on reset the nonvolatile config loads into registers.
// [R15] config load decides whether bus address comes from strap pin.
// [R16] after load the bus opens and the block waits for enable high.
// [R17] with enable high and command off, wait for an on command.
// [R18] with command on, count the 0 to 102.3 ms turn-on delay.
// [R19] after delay, ramp reference to boot voltage; then start-up done.
// [R20] turn-on delay advances 100 us per setting step.
// [R21] firing clears the armed flag, one pulse per token visit.
`ifndef MTS_MAP_SVH
`define MTS_MAP_SVH
`define MTS_OFS_ON_OFF     8'h01
`define MTS_OFS_TURN_ON_DELAY_SETTING  8'h60
`define MTS_OFS_FSW        8'hD1
`define MTS_ON_BIT         7
`define MTS_RST_ON_OFF     8'h80
`define MTS_RST_TURN_ON_DELAY_SETTING  16'h0000
`define MTS_RST_FSW        16'h0032
`define MTS_CLK_KHZ        50000
`define MTS_DELAY_STEP_US  100
`define MTS_DELAY_STEP_CYC ((`MTS_DELAY_STEP_US * `MTS_CLK_KHZ) / 1000)
`define MTS_TOKEN_NS       100
`define MTS_TOKEN_CYC      ((`MTS_TOKEN_NS * `MTS_CLK_KHZ + 999999) / 1000000)
`define MTS_MIN_GAP_CYC    2
`endif

// [design/mts_pkg.sv]
package mts_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } mts_bus_req_s;
  typedef struct packed {
    logic        ack;
    logic        nak;
    logic [15:0] rdata;
  } mts_bus_rsp_s;
  typedef enum logic [2:0] {
    ST_LOAD, ST_WAIT_EN, ST_WAIT_ON, ST_DELAY, ST_RAMP, ST_RUN
  } mts_state_e;
endpackage : mts_pkg

// [tb/mts_properties.sv]
`timescale 1ns/1ps
module mts_checker #(
  parameter int REF_W = 10
) (
  input wire logic                  clock,
  input wire logic                  sys_rst,
  input wire logic                  enable_pin,
  input wire logic                  low_power_standby,
  input wire logic                  local_fault,
  input wire logic [REF_W-1:0]      boot_code,
  input wire mts_pkg::mts_bus_req_s bus_req,
  input wire mts_pkg::mts_bus_rsp_s bus_rsp,
  input wire logic                  turn_on_req,
  input wire logic                  high_side_switch,
  input wire logic                  token_out,
  input wire logic                  is_master,
  input wire logic                  bus_enabled,
  input wire logic                  pg_line_oe_n,
  input wire logic [REF_W-1:0]      ref_code,
  input wire logic                  startup_done
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (sys_rst);
  token_with_on_a:
    assert property ($rose(high_side_switch) |-> $rose(token_out))
    else $error("switch on without token");
  token_width_a:
    assert property ($rose(token_out) |-> token_out[*5] ##1 !token_out)
    else $error("token width off");
  on_after_req_a:
    assert property ($rose(high_side_switch) |-> $past(turn_on_req))
    else $error("switch on without request");
  slave_no_req_a:
    assert property (!is_master |-> !turn_on_req)
    else $error("slave raised request");
  req_gap_a:
    assert property (turn_on_req |=> !turn_on_req)
    else $error("requests too close");
  slave_read_nak_a:
    assert property (bus_req.rd && !bus_req.wr && !is_master && bus_enabled
                     |=> bus_rsp.nak)
    else $error("slave read not refused");
  gated_silent_a:
    assert property ((bus_req.wr || bus_req.rd) && !bus_enabled
                     |=> !(bus_rsp.ack || bus_rsp.nak))
    else $error("gated bus answered");
  lpm_gate_a:
    assert property ((low_power_standby && !enable_pin)[*6] |-> !bus_enabled)
    else $error("bus open in standby");
  ramp_done_a:
    assert property (startup_done |-> ref_code == boot_code)
    else $error("done before boot level");
  slave_alert_a:
    assert property ((!is_master && local_fault)[*4] |-> !pg_line_oe_n)
    else $error("slave fault not reported");
  cover property ($rose(startup_done));
  cover property ($rose(high_side_switch));
  cover property (bus_rsp.nak);
endmodule : mts_checker
bind mts_sequencer mts_checker #(.REF_W(REF_W)) mts_checker_inst (
  .clock, .sys_rst, .enable_pin, .low_power_standby, .local_fault,
  .boot_code, .bus_req, .bus_rsp, .turn_on_req, .high_side_switch,
  .token_out, .is_master, .bus_enabled, .pg_line_oe_n, .ref_code,
  .startup_done
);

// [tb/mts_ring_peer.sv]
`timescale 1ns/1ps
module mts_ring_peer #(
  parameter int HOP = 12
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hold_pull,
  input wire logic token_out,
  output logic     token_in
);
  logic [HOP-1:0] pipe_q;
  // token travels the rest of the chain and returns late
  always_ff @(posedge clock) begin
    if (sys_rst) pipe_q <= '0;
    else pipe_q <= {pipe_q[HOP-2:0], token_out};
  end
  assign token_in = hold_pull | pipe_q[HOP-1];
endmodule : mts_ring_peer

// [tb/mts_sequencer_test.sv]
`timescale 1ns/1ps
module mts_sequencer_test;
  logic                  clock = 1'b0;
  logic                  sys_rst = 1'b1;
  logic                  token_in, hold_pull, pg_line_in, pg_ext;
  logic                  enable_pin, low_power_standby, addr_from_strap;
  logic                  fb_below_ref, local_fault, turn_on_req;
  logic                  high_side_switch, token_out, is_master;
  logic                  bus_enabled, quiet_mode, use_strap_addr;
  logic                  slave_fault, pg_line_oe_n, startup_done;
  logic [15:0]           nv_data, on_time_cyc, fsw_setting, rd;
  logic [15:0]           nv_img [3];
  logic [9:0]            boot_code, ref_code;
  logic [1:0]            nv_addr, an;
  logic                  f;
  int                    n;
  int                    num_errors = 0;
  int                    samples_checked = 0;
  mts_pkg::mts_bus_req_s bus_req;
  mts_pkg::mts_bus_rsp_s bus_rsp;
  assign pg_line_in = pg_line_oe_n & ~pg_ext;
  always #10 clock = ~clock;
  always @(negedge clock) nv_data <= nv_img[nv_addr];
  mts_sequencer #(.DELAY_STEP_CYC(2)) mts_sequencer_inst (
    .clock, .sys_rst, .token_in, .enable_pin, .low_power_standby,
    .addr_from_strap, .nv_data, .fb_below_ref, .on_time_cyc, .boot_code,
    .local_fault, .pg_line_in, .bus_req, .bus_rsp, .nv_addr, .turn_on_req,
    .high_side_switch, .token_out, .is_master, .bus_enabled, .quiet_mode,
    .use_strap_addr, .slave_fault, .pg_line_oe_n, .ref_code, .startup_done,
    .fsw_setting);
  mts_ring_peer mts_ring_peer_inst (
    .clock, .sys_rst, .hold_pull, .token_out, .token_in);
  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", w, e, g);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    an = 2'b00;
    rd = 16'h0000;
    @(negedge clock);
    bus_req = '{wr, ~wr, a, d};
    @(negedge clock);
    bus_req = '0;
    repeat (2) begin
      if (bus_rsp.ack || bus_rsp.nak) begin
        an = {bus_rsp.ack, bus_rsp.nak};
        rd = bus_rsp.rdata;
      end
      @(negedge clock);
    end
  endtask : bus
  task automatic boot(input logic mst, input logic [15:0] onoff);
    @(negedge clock);
    sys_rst = 1'b1;
    hold_pull = mst;
    nv_img[0] = onoff;
    repeat (8) @(negedge clock);
    sys_rst = 1'b0;
    repeat (10) @(negedge clock);
  endtask : boot
  task automatic fire;
    f = 1'b0;
    n = 0;
    fb_below_ref = 1'b1;
    @(negedge clock);
    fb_below_ref = 1'b0;
    repeat (6) if (!f) begin
      @(negedge clock);
      f = high_side_switch;
    end
    while (f && high_side_switch && n < 40) begin
      n++;
      @(negedge clock);
    end
  endtask : fire
  task automatic t_load;
    boot(1'b1, 16'h0000);
    chk("master", 16'h1, is_master);
    chk("strap", 16'h1, use_strap_addr);
    bus(1'b0, 8'hD1, 16'h0);
    chk("fsw", 16'h0041, rd);
    chk("ack", 16'h2, an);
    bus(1'b0, 8'h60, 16'h0);
    chk("delay", 16'h0003, rd);
    bus(1'b0, 8'h02, 16'h0);
    chk("unmapped", 16'h1, an);
    enable_pin = 1'b1;
    repeat (20) @(negedge clock);
    chk("idle", 16'h0, startup_done);
  endtask : t_load
  task automatic t_delay;
    bus(1'b1, 8'h01, 16'h0080);
    n = 0;
    while (!startup_done && n < 500) begin
      n++;
      @(negedge clock);
    end
    chk("late", 16'h1, n >= 18 && n <= 34);
    chk("boot", 16'h010, ref_code);
    hold_pull = 1'b0;
  endtask : t_delay
  task automatic t_ring;
    repeat (30) @(negedge clock);
    fire();
    chk("first", 16'h1, f);
    chk("width", 16'h7, n);
    fire();
    chk("rearm", 16'h0, f);
    repeat (30) @(negedge clock);
    fire();
    chk("pass", 16'h1, f);
    pg_ext = 1'b1;
    repeat (6) @(negedge clock);
    pg_ext = 1'b0;
    chk("pgmon", 16'h1, slave_fault);
  endtask : t_ring
  task automatic t_gate;
    enable_pin = 1'b0;
    bus(1'b0, 8'h60, 16'h0);
    chk("regular", 16'h2, an);
    low_power_standby = 1'b1;
    repeat (8) @(negedge clock);
    bus(1'b1, 8'h60, 16'h0004);
    chk("gated", 16'h0, an);
    chk("quiet", 16'h1, quiet_mode);
    low_power_standby = 1'b0;
    enable_pin = 1'b1;
  endtask : t_gate
  task automatic t_slave;
    boot(1'b0, 16'h0080);
    chk("slave", 16'h0, is_master);
    bus(1'b0, 8'h60, 16'h0);
    chk("slvrd", 16'h1, an);
    bus(1'b1, 8'h60, 16'h0007);
    chk("slvwr", 16'h2, an);
    local_fault = 1'b1;
    repeat (6) @(negedge clock);
    chk("alert", 16'h0, pg_line_oe_n);
    local_fault = 1'b0;
  endtask : t_slave
  initial begin
    {enable_pin, low_power_standby, fb_below_ref, local_fault} = 4'h0;
    {hold_pull, pg_ext, addr_from_strap} = 3'b101;
    bus_req = '0;
    on_time_cyc = 16'h0007;
    boot_code = 10'h010;
    nv_img = '{16'h0000, 16'h0003, 16'h0041};
    t_load();
    t_delay();
    t_ring();
    t_gate();
    t_slave();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    close_out();
  end
endmodule : mts_sequencer_test
